// File: dv/receiver_sequence_frame_config_tb.sv
// bench: host end and decoder end joined by the link, driven over apb
// assumes decoder delay unit shortened to 4 cycles
`timescale 1ns/100ps
module receiver_sequence_frame_config_tb;
  import rsfc_pkg::*;
  logic sys_clk_in = 0, rst_b_in = 0, psel_in = 0, penable_in = 0;
  logic pwrite_in = 0, on_go_in = 0, shut_go_in = 0, low_battery_in = 0;
  logic hand_collapse_in = 0, pready_out, pslverr_out, e;
  logic battery_low_out, frame_claimed_out, busy_out;
  logic [1:0] on_pick_in = 2'h0;
  logic [6:0] frame_sel_in = 7'h00;
  logic [7:0] paddr_in = 8'h00, rx_ctrl_lines_out;
  logic [15:0] collapse_mask_in = 16'h0000;
  logic [31:0] pwdata_in = 32'h0000_0000, prdata_out, q;
  int n_mismatch = 0, n_tests = 0, n_pk = 0, cnt;
  always #50 sys_clk_in = ~sys_clk_in;
  rsfc_link_if link ();
  rsfc_host u_rsfc_host (.sys_clk_in, .rst_b_in, .psel_in, .penable_in,
    .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out,
    .pslverr_out, .link(link));
  rsfc_decoder #(.UNIT_CYCLES(4)) u_rsfc_decoder (.sys_clk_in, .rst_b_in,
    .link(link), .on_pick_in, .on_go_in, .shut_go_in, .low_battery_in,
    .hand_collapse_in, .collapse_mask_in, .frame_sel_in, .rx_ctrl_lines_out,
    .battery_low_out, .frame_claimed_out, .busy_out);
  rsfc_props u_rsfc_props (.sys_clk_in, .rst_b_in, .psel_in, .penable_in,
    .pwrite_in, .paddr_in, .pwdata_in, .pready_out,
    .pkt_valid(link.pkt_valid), .pkt_data(link.pkt_data), .on_pick_in,
    .on_go_in, .shut_go_in, .hand_collapse_in, .frame_sel_in,
    .rx_ctrl_lines_out, .battery_low_out, .frame_claimed_out, .busy_out);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer; values sampled at the edge that sees pready
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge sys_clk_in);
    psel_in <= 1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge sys_clk_in);
    penable_in <= 1;
    do @(posedge sys_clk_in); while (pready_out !== 1'b1);
    q = prdata_out;
    e = pslverr_out;
    psel_in <= 0;
    penable_in <= 0;
    if (w && a == REG_TX_DATA) n_pk++;
    repeat (2) @(posedge sys_clk_in);
  endtask
  task automatic pulse(input logic sh, input logic [1:0] p);
    @(posedge sys_clk_in);
    on_pick_in <= p;
    on_go_in <= !sh;
    shut_go_in <= sh;
    @(posedge sys_clk_in);
    on_go_in <= 0;
    shut_go_in <= 0;
  endtask
  task automatic query(input logic [6:0] f, input logic x);
    @(posedge sys_clk_in);
    frame_sel_in <= f;
    repeat (3) @(posedge sys_clk_in);
    chk(frame_claimed_out, x);
  endtask
  task automatic report_and_stop;
    $display("counts: %0d compares, %0d mismatches", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge sys_clk_in);
    rst_b_in <= 1;
    hand_collapse_in <= 1;
    // flags set before any run request
    // one flag per range, walking down the map
    for (int f = 0; f < 8; f++)
      xfer(1, REG_TX_DATA, {FRAME_CODE, 3'(f), 8'h00, 16'h0001 << f});
    for (int f = 0; f < 8; f++) begin
      query(7'(112 - 15 * f), 1);
      query(7'(113 - 15 * f), 0);
    end
    // outside manual mode the answer is gated by the collapse mask
    hand_collapse_in <= 0;
    query(7'd112, 0);
    collapse_mask_in <= 16'hffff;
    query(7'd112, 1);
    $display("test frame map done");
    low_battery_in <= 1;
    xfer(1, REG_TX_DATA, {ON_NIBBLE, SEL_DATA32, 8'h08, 8'ha5, 8'h00});
    xfer(1, REG_TX_DATA, {ON_NIBBLE, SEL_SYNC16, 8'h00, 8'h69, 8'h00});
    xfer(1, REG_TX_DATA, {SHUT_CODE, 1'b0, 8'h88, 8'h3c, 8'h02});
    pulse(0, 2'd3);
    @(posedge sys_clk_in);
    chk(busy_out, 0);
    pulse(0, 2'd1);
    @(posedge sys_clk_in);
    chk(rx_ctrl_lines_out, 8'ha5);
    repeat (3) @(posedge sys_clk_in);
    chk(rx_ctrl_lines_out, 8'ha5);
    pulse(0, 2'd0);
    @(posedge sys_clk_in);
    chk(rx_ctrl_lines_out, 8'h69);
    chk(battery_low_out, 1);
    low_battery_in <= 0;
    pulse(1, 2'd0);
    cnt = 0;
    while (busy_out === 1'b1 && cnt < 100) begin
      @(posedge sys_clk_in);
      cnt++;
    end
    // two units of four clocks, plus the edge that shows idle
    chk(cnt, 2 * 4 + 1);
    chk(rx_ctrl_lines_out, 8'h3c);
    chk(battery_low_out, 0);
    $display("test shut sequence done");
    xfer(1, REG_TX_DATA, {SHUT_CODE, 1'b0, 8'h00, 8'h5a, 8'h01});
    pulse(0, 2'd2);
    pulse(1, 2'd2);
    repeat (3) @(posedge sys_clk_in);
    chk({busy_out, rx_ctrl_lines_out}, 9'h000);
    pulse(1, 2'd0);
    @(posedge sys_clk_in);
    chk(busy_out, 0);
    xfer(0, REG_STATUS, 0);
    chk(q[15:0], n_pk[15:0]);
    xfer(0, 8'h10, 0);
    chk(e, 1);
    $display("test skip and status done");
    report_and_stop;
  end
  initial begin
    repeat (5000) @(posedge sys_clk_in);
    n_mismatch++;
    report_and_stop;
  end
endmodule // receiver_sequence_frame_config_tb

// File: dv/rsfc_props.sv
// rsfc_props: concurrent checks on the packet link and the decoder pins
// assumes one clock domain; instantiated beside the link by the bench
`timescale 1ns/100ps
module rsfc_props import rsfc_pkg::*; (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic pready_out,
  input wire logic pkt_valid,
  input wire logic [31:0] pkt_data,
  input wire logic [1:0] on_pick_in,
  input wire logic on_go_in,
  input wire logic shut_go_in,
  input wire logic hand_collapse_in,
  input wire logic [6:0] frame_sel_in,
  input wire logic [7:0] rx_ctrl_lines_out,
  input wire logic battery_low_out,
  input wire logic frame_claimed_out,
  input wire logic busy_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);
  property p_tx_pkt;
    psel_in && penable_in && !pready_out && pwrite_in &&
      paddr_in == REG_TX_DATA |=> pkt_valid && pkt_data == $past(pwdata_in);
  endproperty
  a_tx_pkt: assert property (p_tx_pkt)
    else $error("packet write not sent on link");
  property p_strobe;
    pkt_valid |=> !pkt_valid;
  endproperty
  a_strobe: assert property (p_strobe)
    else $error("packet strobe longer than one cycle");
  property p_go_busy;
    !busy_out && on_go_in && on_pick_in != 2'd3 |=> busy_out;
  endproperty
  a_go_busy: assert property (p_go_busy)
    else $error("on request did not start sequence");
  property p_go_bad;
    !busy_out && on_go_in && on_pick_in == 2'd3 |=> !busy_out;
  endproperty
  a_go_bad: assert property (p_go_bad)
    else $error("unknown on selector started sequence");
  property p_idle_hold;
    !busy_out && !on_go_in |=> $stable(rx_ctrl_lines_out);
  endproperty
  a_idle_hold: assert property (p_idle_hold)
    else $error("control lines moved while idle");
  property p_shut_idle;
    !busy_out && !on_go_in && shut_go_in |=> !busy_out;
  endproperty
  a_shut_idle: assert property (p_shut_idle)
    else $error("shut request left idle");
  property p_probe;
    $changed(battery_low_out) |-> $past(busy_out);
  endproperty
  a_probe: assert property (p_probe)
    else $error("battery sample taken outside a state exit");
  // with manual collapse the query result depends on flags and frame only
  property p_hand;
    $past(hand_collapse_in) && $past(hand_collapse_in, 2) &&
      $past(frame_sel_in) == $past(frame_sel_in, 2) && !$past(pkt_valid, 2)
      && !$past(pkt_valid, 3) && !$past(pkt_valid, 4)
      |-> $stable(frame_claimed_out);
  endproperty
  a_hand: assert property (p_hand)
    else $error("frame flag changed under manual collapse");
endmodule // rsfc_props

// File: hdl/rsfc_decoder.sv
// rsfc_decoder: stores receiver and frame settings, runs the sequence
// assumes packets arrive as one-cycle strobes; run/collapse are plain pins
`timescale 1ns/100ps
// Contract
// - on packet 0001 plus state selector
// - sample battery before leaving probed state
// - drive stored line value in state
// - shut packet 0001101 plus step bit
// - disabled step skips rest of shutdown
// - step delay in 625 us units
// - frame packets 00100 plus range selector
// - selector zero maps frames 127 to 112
// - host sets a flag before run
// - set flag means frame is decoded
// - host sets flags per home frame
// - manual collapse leaves flags untouched
// - host retunes after wanted frames decoded
// - host leaves settings alone while running
// - twelve receiver settings ids 16-27
module rsfc_decoder import rsfc_pkg::*; #(
  parameter int unsigned UNIT_CYCLES = UNIT_CYC
) (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  rsfc_link_if.decoder link,
  input wire logic [1:0] on_pick_in, // 0 sync16, 1 data32, 2 data16
  input wire logic on_go_in, // pulse: enter selected on-state
  input wire logic shut_go_in, // pulse: start shut-down
  input wire logic low_battery_in, // low-battery input
  input wire logic hand_collapse_in, // manual collapse mode
  input wire logic [15:0] collapse_mask_in, // over-the-air collapse
  input wire logic [6:0] frame_sel_in, // frame to query
  output logic [7:0] rx_ctrl_lines_out,
  output logic battery_low_out,
  output logic frame_claimed_out,
  output logic busy_out
);
  logic [7:0] on_line [3]; // stored line per on-state
  logic [2:0] on_probe; // per on-state probe flag
  logic [7:0] shut_line [2]; // line value per shut-down step
  logic [1:0] shut_probe; // per step probe flag
  logic [1:0] shut_entry_on; // per step enable flag
  logic [5:0] shut_delay [2]; // per step delay in units
  logic [15:0] frame_flags [8]; // frame_claimed map, 8 groups
  rsfc_phase_type phase; // where the sequencer is
  logic [1:0] cur_on; // current on-state index
  logic [5:0] ticks; // delay units left
  logic [12:0] sub; // cycles within one unit
  logic [7:0] top; // top byte of the incoming packet
  logic [6:0] fpos; // queried frame as group and bit
  logic [2:0] grp; // flag group of the queried frame
  logic [3:0] bitn; // flag bit within that group
  logic [15:0] eff; // group after collapse masking, if any
  assign top = link.pkt_data[TOP_MSB:TOP_LSB];

  // map a frame number to flag group and bit index
  function automatic logic [6:0] frame_pos(input logic [6:0] f);
    frame_pos = {3'(~f[6:4]), f[3:0]};
  endfunction

  // query path in named steps: a bit-select of a function result or of
  // a masked expression is not legal, so each step gets a signal
  assign fpos = frame_pos(frame_sel_in);
  assign grp = fpos[6:4];
  assign bitn = fpos[3:0];
  // manual keeps flags
  // over-the-air collapse masks the group only outside manual mode
  assign eff = hand_collapse_in ? frame_flags[grp]
    : frame_flags[grp] & collapse_mask_in;

  // packet decode stores settings; receiver ids 16-27 only
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      // settings clear, delays start at one unit
      for (int i = 0; i < 3; i++) on_line[i] <= LINE_RST;
      on_probe <= 3'b000;
      for (int i = 0; i < 2; i++) begin
        shut_line[i] <= LINE_RST;
        shut_delay[i] <= DELAY_RST;
      end
      shut_probe <= 2'b00;
      shut_entry_on <= 2'b00;
      for (int i = 0; i < 8; i++) frame_flags[i] <= FLAGS_RST;
    end else if (link.pkt_valid) begin
      // packets of other kinds fall through and change nothing
      // receiver id space
      if (top[7:4] == ON_NIBBLE) begin
        if (top[3:0] == SEL_SYNC16 || top[3:0] == SEL_DATA32
            || top[3:0] == SEL_DATA16) begin
          // selector minus the sync code gives index 0, 1 or 2
          on_line[2'(top[3:0] - SEL_SYNC16)] <=
            link.pkt_data[LINE_MSB:LINE_LSB];
          on_probe[2'(top[3:0] - SEL_SYNC16)] <=
            link.pkt_data[PROBE_BIT];
        end else if (top[7:1] == SHUT_CODE) begin
          // shut step select
          // bit 0 of the top byte picks step one or two
          shut_line[top[0]] <= link.pkt_data[LINE_MSB:LINE_LSB];
          shut_probe[top[0]] <= link.pkt_data[PROBE_BIT];
          shut_entry_on[top[0]] <= link.pkt_data[ENTRY_ON_BIT];
          shut_delay[top[0]] <= link.pkt_data[DELAY_MSB:0];
        end
      end else if (top[7:3] == FRAME_CODE) begin
        // frame packet
        // the selector only picks which group of sixteen is replaced
        frame_flags[top[2:0]] <= link.pkt_data[15:0];
      end
    end
  end

  // frame query; collapse mask applies only outside manual mode
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      frame_claimed_out <= 1'b0;
    end else begin
      frame_claimed_out <= eff[bitn];
    end
  end

  // sequencer: on-states, then two timed shut-down steps
  // trade-off: only shut-down steps are timed; on-states carry no delay
  // and hold until the next request
  // limitation: sub is 13 bits, so one unit may be at most 8192 clocks
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      // lines low and no battery sample until the first request
      phase <= RSFC_IDLE;
      cur_on <= 2'd0;
      ticks <= 6'd0;
      sub <= 13'd0;
      rx_ctrl_lines_out <= LINE_RST;
      battery_low_out <= 1'b0;
      busy_out <= 1'b0;
    end else begin
      case (phase)
        RSFC_IDLE: begin
          busy_out <= 1'b0;
          // selector 3 names no on-state and a shut request has nothing
          // to shut down here, so both are ignored
          if (on_go_in && on_pick_in != 2'd3) begin
            phase <= RSFC_ON;
            cur_on <= on_pick_in;
            busy_out <= 1'b1;
            rx_ctrl_lines_out <= on_line[on_pick_in];
          end
        end
        RSFC_ON: begin
          rx_ctrl_lines_out <= on_line[cur_on];
          // leave on a request for another on-state or for shut-down;
          // asking for the state already held changes nothing
          if (on_go_in && on_pick_in != 2'd3 && on_pick_in != cur_on
              || shut_go_in) begin
            if (on_probe[cur_on]) battery_low_out <= low_battery_in;
            if (shut_go_in) begin
              if (shut_entry_on[0]) begin
                phase <= RSFC_SHUT1;
                rx_ctrl_lines_out <= shut_line[0];
                ticks <= shut_delay[0];
                sub <= 13'd0;
              end else begin
                // step one disabled: the whole shut-down is skipped
                phase <= RSFC_IDLE;
                busy_out <= 1'b0;
              end
            end else begin
              // straight to the new on-state, no delay between
              cur_on <= on_pick_in;
              rx_ctrl_lines_out <= on_line[on_pick_in];
            end
          end
        end
        RSFC_SHUT1, RSFC_SHUT2: begin
          // sub counts clocks in a unit, ticks counts units left
          // unit countdown
          if (sub == 13'(UNIT_CYCLES - 1)) begin
            sub <= 13'd0;
            ticks <= ticks - 6'd1;
          end else begin
            sub <= sub + 13'd1;
          end
          // last clock of the last unit; a delay of 0 also ends here
          // after one unit, since the test is ticks <= 1
          if (ticks <= 6'd1 && sub == 13'(UNIT_CYCLES - 1)) begin
            if (phase == RSFC_SHUT1 ? shut_probe[0] : shut_probe[1])
              battery_low_out <= low_battery_in;
            if (phase == RSFC_SHUT1 && shut_entry_on[1]) begin
              // step two starts with a fresh count
              phase <= RSFC_SHUT2;
              rx_ctrl_lines_out <= shut_line[1];
              ticks <= shut_delay[1];
            end else begin
              // done or step two disabled: lines keep the last value
              phase <= RSFC_IDLE;
              busy_out <= 1'b0;
            end
          end
        end
        // unused phase codes fall back to idle
        default: phase <= RSFC_IDLE;
      endcase
    end
  end
endmodule // rsfc_decoder

// File: hdl/rsfc_host.sv
// rsfc_host: apb slave that sends packets over the link
// assumes software writes whole packets to the data register
`timescale 1ns/100ps
module rsfc_host import rsfc_pkg::*; (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  rsfc_link_if.host link
);
  logic [15:0] sent_count; // packets sent, readable
  logic acc; // access phase
  assign acc = psel_in && penable_in && !pready_out;

  // one wait state: ready comes one cycle into the access phase
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h0000_0000;
    end else begin
      pready_out <= acc;
      pslverr_out <= acc && paddr_in != REG_TX_DATA
        && paddr_in != REG_STATUS;
      // status reads show the packet count; tx data reads as zero
      if (acc && !pwrite_in && paddr_in == REG_STATUS) begin
        prdata_out <= {16'h0000, sent_count};
      end else begin
        prdata_out <= 32'h0000_0000;
      end
    end
  end

  // write to the data register launches one packet; host
  // in software by what it writes here
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      link.pkt_valid <= 1'b0;
      link.pkt_data <= 32'h0000_0000;
      sent_count <= 16'h0000;
    end else begin
      link.pkt_valid <= acc && pwrite_in && paddr_in == REG_TX_DATA;
      if (acc && pwrite_in && paddr_in == REG_TX_DATA) begin
        link.pkt_data <= pwdata_in;
        sent_count <= sent_count + 16'h0001;
      end
    end
  end
endmodule // rsfc_host

// File: hdl/rsfc_link_if.sv
// rsfc_link_if: packet link between host end and decoder end
// assumes a single shared clock; one-cycle strobe carries one packet
`timescale 1ns/100ps
interface rsfc_link_if;
  logic pkt_valid; // one-cycle packet strobe
  logic [31:0] pkt_data; // packet word
  modport host (output pkt_valid, output pkt_data);
  modport decoder (input pkt_valid, input pkt_data);
endinterface

// File: hdl/rsfc_pkg.sv
// rsfc_pkg: shared constants for the receiver sequence and frame config link
// assumes both ends import it; packets are 32 bits, top byte first in fields
package rsfc_pkg;
  // packet field positions
  localparam int unsigned PKT_W = 32;
  localparam int unsigned TOP_MSB = 31;
  localparam int unsigned TOP_LSB = 24;
  localparam int unsigned ENTRY_ON_BIT = 23;
  localparam int unsigned PROBE_BIT = 19;
  localparam int unsigned LINE_MSB = 15;
  localparam int unsigned LINE_LSB = 8;
  localparam int unsigned DELAY_MSB = 5;
  // top byte codes
  localparam logic [3:0] ON_NIBBLE = 4'h1;
  localparam logic [3:0] SEL_SYNC16 = 4'h7;
  localparam logic [3:0] SEL_DATA32 = 4'h8;
  localparam logic [3:0] SEL_DATA16 = 4'h9;
  localparam logic [6:0] SHUT_CODE = 7'h0d;
  localparam logic [4:0] FRAME_CODE = 5'h04;
  // reset values
  localparam logic [7:0] LINE_RST = 8'h00;
  localparam logic [5:0] DELAY_RST = 6'h01;
  localparam logic [15:0] FLAGS_RST = 16'h0000;
  localparam int unsigned FRAMES = 128;
  // timing: one delay unit is 625 us
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned UNIT_US = 625;
  localparam int unsigned UNIT_CYC = (CLK_HZ / 1_000_000) * UNIT_US;
  // host apb register offsets
  localparam logic [7:0] REG_TX_DATA = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  // decoder phase states
  typedef enum logic [2:0] {
    RSFC_IDLE, RSFC_ON, RSFC_SHUT1, RSFC_SHUT2
  } rsfc_phase_type;
endpackage
